// File: logic/lld_pkg.sv
package lld_pkg;
    // request commands from the user side
    typedef enum logic [1:0] {
        CMD_READ  = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_REFR  = 2'b10
    } lld_cmd_t;

    // sequencer states, gray along load -> mrs -> idle -> xfer
    typedef enum logic [2:0] {
        ST_LOAD = 3'b000,
        ST_MRS  = 3'b001,
        ST_IDLE = 3'b011,
        ST_XFER = 3'b010,
        ST_GAP  = 3'b110
    } lld_state_t;

    ////////////////////////////////////////////////////////////////////////
    // configuration field widths
    localparam int TRC_W  = 4;
    localparam int LAT_W  = 4;
    localparam int ODT_W  = 2;
    localparam int BL_W   = 2;
    localparam int WP_W   = 2;
    localparam int MR_W   = 8;
    localparam int MR_N   = 3;
    localparam int CNT_W  = 5;
    localparam int GRP_W  = 9;     // data bits per write data group
    localparam int MAX_W  = 72;    // widest combined data bus
    localparam int MAX_MB = 4;     // most banks per multi-bank refresh

    // mode word 0 layout
    localparam int MR0_TRC_LSB = 0;
    localparam int MR0_LAT_LSB = 4;
    // mode word 1 layout
    localparam int MR1_DRV_POS = 0;
    localparam int MR1_ODT_LSB = 1;
    localparam int MR1_ARF_POS = 3;
    localparam int MR1_BL_LSB  = 4;
    // mode word 2 layout
    localparam int MR2_WP_LSB  = 0;

    // burst length codes
    localparam logic [BL_W-1:0] BL_2 = 2'h0;
    localparam logic [BL_W-1:0] BL_4 = 2'h1;
    localparam logic [BL_W-1:0] BL_8 = 2'h2;

    // mode-set spacing
    localparam int CLK_NS  = 100;
    localparam int MRD_NS  = 30;
    localparam int MRD_RAW = (MRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC = (MRD_RAW < 1) ? 1 : MRD_RAW;

    // pin levels
    localparam logic [1:0] CS_NONE = 2'h3;
    localparam logic [1:0] CS_BOTH = 2'h0;
    localparam logic [1:0] CS_DIE0 = 2'h2;
    localparam logic [1:0] CS_DIE1 = 2'h1;
endpackage : lld_pkg

// File: logic/lld_mr_store.sv
`timescale 1ns/1ps
module lld_mr_store #(
    parameter int DW = 8,
    parameter int DEPTH = 3,
    parameter int AW = 2
) (
    input  wire logic          clk,   // system clock
    input  wire logic          nrst,  // async reset, active low
    input  wire logic          we,    // write strobe
    input  wire logic [AW-1:0] waddr, // write index
    input  wire logic [DW-1:0] wdata, // write word
    input  wire logic [AW-1:0] raddr, // read index
    output logic      [DW-1:0] rdata  // registered read word
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // out-of-range index reads zero
    always_comb begin
        rdata_nxt = '0;
        if (int'(raddr) < DEPTH) begin
            rdata_nxt = mem[raddr];
        end
    end

    // words hold no reset; they are loaded before ever being read
    always_ff @(posedge clk) begin
        if (we && int'(waddr) < DEPTH) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule : lld_mr_store

// File: logic/lld_cfg_ctrl.sv
`timescale 1ns/1ps
module lld_cfg_ctrl #(
    parameter int DQ_W      = 18,
    parameter bit WM_EN     = 1'b1,
    parameter bit WIDTH_EXP = 1'b0,
    parameter bit DEPTH_EXP = 1'b0,
    parameter int ADDR_W    = 20,
    parameter int BA_W      = 4,
    localparam int TOT_W    = WIDTH_EXP ? 2 * DQ_W : DQ_W,
    localparam int WM_N     = TOT_W / lld_pkg::GRP_W,
    localparam int UA_W     = ADDR_W + (DEPTH_EXP ? 1 : 0)
) (
    input  wire logic                       clk,        // 10 MHz clock
    input  wire logic                       nrst,       // async reset
    input  wire logic [lld_pkg::TRC_W-1:0]  cfgTrc,     // row cycle code
    input  wire logic [lld_pkg::LAT_W-1:0]  cfgLat,     // data latency
    input  wire logic                       cfgDrive,   // output drive
    input  wire logic [lld_pkg::ODT_W-1:0]  cfgOdt,     // termination
    input  wire logic                       cfgArefMb,  // multi-bank refresh
    input  wire logic [lld_pkg::BL_W-1:0]   cfgBurst,   // burst code
    input  wire logic [lld_pkg::WP_W-1:0]   cfgWrProto, // write protocol
    input  wire logic                       reqValid,   // request present
    input  wire lld_pkg::lld_cmd_t          reqCmd,     // request kind
    input  wire logic [UA_W-1:0]            reqAddr,    // row/col or mask
    input  wire logic [BA_W-1:0]            reqBank,    // bank
    input  wire logic [TOT_W-1:0]           wrData,     // write beat
    input  wire logic [WM_N-1:0]            wrMask,     // write beat mask
    input  wire logic [TOT_W-1:0]           memDqI,     // data pins in
    output logic                            reqReady_r, // request taken
    output logic                            reqErr_r,   // refresh refused
    output logic                            initDone_r, // mode words sent
    output logic                            wrTake_r,   // wrData sampled
    output logic [TOT_W-1:0]                rdData_r,   // read beat
    output logic                            rdValid_r,  // read beat valid
    output logic [1:0]                      memCsN_r,   // chip selects
    output logic                            memWeN_r,   // write enable
    output logic                            memRefN_r,  // refresh strobe
    output logic [ADDR_W-1:0]               memAddr_r,  // address pins
    output logic [BA_W-1:0]                 memBa_r,    // bank pins
    output logic [TOT_W-1:0]                memDqO_r,   // data pins out
    output logic                            memDqOe_r,  // data pin enable
    output logic [WM_N-1:0]                 memWm_r     // write mask pins
);
    import lld_pkg::*;

    localparam int NB = 1 << BA_W;

    lld_state_t        stR, stNxt;
    logic [1:0]        idxR, idxNxt;
    logic [CNT_W-1:0]  cntR, cntNxt;
    logic [LAT_W-1:0]  latR, latNxt;
    logic [CNT_W-1:0]  bcR, bcNxt;
    logic [TRC_W-1:0]  trcR, trcNxt;
    logic              arefR, arefNxt, isWrR, isWrNxt;
    logic              storeWe;
    logic [MR_W-1:0]   mrRd, mrWr;
    logic              ready_nxt, err_nxt, done_nxt, take_nxt, rdv_nxt, oe_nxt;
    logic [TOT_W-1:0]  rdData_nxt, dqO_nxt;
    logic [1:0]        cs_nxt;
    logic              we_nxt, ref_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic [BA_W-1:0]   ba_nxt;
    logic [WM_N-1:0]   wm_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [CNT_W-1:0] burstBeats(input logic [BL_W-1:0] c);
        case (c)
            BL_2:    burstBeats = CNT_W'(2);
            BL_4:    burstBeats = CNT_W'(4);
            default: burstBeats = CNT_W'(8);
        endcase
    endfunction : burstBeats

    function automatic logic [BA_W:0] popCnt(input logic [NB-1:0] m);
        popCnt = '0;
        for (int i = 0; i < NB; i++) begin
            popCnt = popCnt + (BA_W + 1)'(m[i]);
        end
    endfunction : popCnt

    // true while pin cycle x lies in the data window after the command
    function automatic logic inWin(input logic [CNT_W:0] x,
                                   input logic [LAT_W-1:0] l,
                                   input logic [CNT_W-1:0] b);
        inWin = (x >= (CNT_W + 1)'(l)) && (x < (CNT_W + 1)'(l) + (CNT_W + 1)'(b));
    endfunction : inWin

    // the latency code lands in the mode word as given and in latR with zero raised to one
    function automatic logic [MR_W-1:0] mrWord(input logic [1:0] i);
        mrWord = '0;
        case (i)
            2'd0: begin
                mrWord[MR0_TRC_LSB +: TRC_W] = cfgTrc;
                mrWord[MR0_LAT_LSB +: LAT_W] = cfgLat;
            end
            2'd1: begin
                mrWord[MR1_DRV_POS] = cfgDrive;
                mrWord[MR1_ODT_LSB +: ODT_W] = cfgOdt;
                mrWord[MR1_ARF_POS] = cfgArefMb;
                mrWord[MR1_BL_LSB +: BL_W] = cfgBurst;
            end
            default: mrWord[MR2_WP_LSB +: WP_W] = cfgWrProto;
        endcase
    endfunction : mrWord

    // mode word memory, loaded once after reset
    lld_mr_store #(.DW(MR_W), .DEPTH(MR_N), .AW(2)) uStore (
        .clk   (clk),
        .nrst  (nrst),
        .we    (storeWe),
        .waddr (idxR),
        .wdata (mrWr),
        .raddr (idxR),
        .rdata (mrRd)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer and pin drive, next values
    always_comb begin
        stNxt = stR;  idxNxt = idxR;  cntNxt = cntR;
        latNxt = latR;  bcNxt = bcR;  trcNxt = trcR;
        arefNxt = arefR;  isWrNxt = isWrR;  storeWe = 1'b0;
        mrWr = mrWord(idxR);
        err_nxt = 1'b0;  done_nxt = initDone_r;  take_nxt = 1'b0;
        rdv_nxt = 1'b0;  oe_nxt = 1'b0;  rdData_nxt = rdData_r;
        cs_nxt = CS_NONE;  we_nxt = 1'b1;  ref_nxt = 1'b1;
        addr_nxt = memAddr_r;  ba_nxt = memBa_r;
        // pin data follows each sampled write beat
        dqO_nxt = wrTake_r ? wrData : memDqO_r;
        wm_nxt = (wrTake_r && WM_EN) ? wrMask : (WM_EN ? memWm_r : '0);
        case (stR)
            ST_LOAD: begin
                storeWe = 1'b1;
                if (idxR == 2'd0) begin
                    latNxt = (cfgLat == '0) ? LAT_W'(1) : cfgLat;
                    bcNxt = burstBeats(cfgBurst);
                    // zero asks the block to follow the latency
                    trcNxt = (cfgTrc == '0) ? latNxt : cfgTrc;
                    arefNxt = cfgArefMb;
                end
                if (idxR == 2'(MR_N - 1)) begin
                    stNxt = ST_MRS;
                    idxNxt = '0;
                    cntNxt = CNT_W'(MRD_CYC);
                end else begin
                    idxNxt = idxR + 2'd1;
                end
            end
            ST_MRS: begin
                if (cntR != '0) begin
                    cntNxt = cntR - CNT_W'(1);
                end else begin
                    // every device sees every mode word
                    cs_nxt = (WIDTH_EXP || DEPTH_EXP) ? CS_BOTH : CS_DIE0;
                    we_nxt = 1'b0;
                    ref_nxt = 1'b0;
                    addr_nxt = {{(ADDR_W - MR_W){1'b0}}, mrRd};
                    ba_nxt = BA_W'(idxR);
                    cntNxt = CNT_W'(MRD_CYC);
                    if (idxR == 2'(MR_N - 1)) begin
                        stNxt = ST_GAP;
                        done_nxt = 1'b1;
                    end else begin
                        idxNxt = idxR + 2'd1;
                    end
                end
            end
            ST_IDLE: begin
                if (reqValid && reqReady_r) begin
                    addr_nxt = reqAddr[ADDR_W-1:0];
                    ba_nxt = reqBank;
                    cs_nxt = WIDTH_EXP ? CS_BOTH : CS_DIE0;
                    if (DEPTH_EXP) begin
                        // top address bit picks the die
                        cs_nxt = reqAddr[UA_W-1] ? CS_DIE1 : CS_DIE0;
                    end
                    isWrNxt = (reqCmd == CMD_WRITE);
                    cntNxt = '0;
                    case (reqCmd)
                        CMD_REFR: begin
                            ref_nxt = 1'b0;
                            if (arefR && popCnt(reqAddr[NB-1:0]) >
                                (BA_W + 1)'(MAX_MB)) begin
                                err_nxt = 1'b1;
                                cs_nxt = CS_NONE;
                                ref_nxt = 1'b1;
                            end else begin
                                // mask on address pins or bank on bank pins
                                if (arefR) begin
                                    ba_nxt = '0;
                                end
                                stNxt = ST_GAP;
                                cntNxt = CNT_W'(trcR) - CNT_W'(1);
                            end
                        end
                        CMD_WRITE: begin
                            we_nxt = 1'b0;
                            stNxt = ST_XFER;
                            take_nxt = inWin((CNT_W + 1)'(1), latR, bcR);
                        end
                        default: begin
                            stNxt = ST_XFER;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                cntNxt = cntR + CNT_W'(1);
                // launch and capture share one window
                if (isWrR) begin
                    take_nxt = inWin({1'b0, cntR} + (CNT_W + 1)'(2), latR, bcR);
                    oe_nxt = inWin({1'b0, cntR} + (CNT_W + 1)'(1), latR, bcR);
                end else begin
                    rdv_nxt = inWin({1'b0, cntR}, latR, bcR);
                    rdData_nxt = memDqI;
                end
                if (cntR == CNT_W'(latR) + bcR) begin
                    stNxt = ST_IDLE;
                end
            end
            ST_GAP: begin
                if (cntR == '0) begin
                    stNxt = ST_IDLE;
                end else begin
                    cntNxt = cntR - CNT_W'(1);
                end
            end
            default: begin
                stNxt = ST_LOAD;
                idxNxt = '0;
            end
        endcase
        ready_nxt = (stNxt == ST_IDLE);
    end

    // all state and pins registered; pins idle deselected after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stR <= ST_LOAD;  idxR <= '0;  cntR <= '0;
            latR <= LAT_W'(1);  bcR <= CNT_W'(2);  trcR <= TRC_W'(1);
            arefR <= 1'b0;  isWrR <= 1'b0;
            reqReady_r <= 1'b0;  reqErr_r <= 1'b0;  initDone_r <= 1'b0;
            wrTake_r <= 1'b0;  rdData_r <= '0;  rdValid_r <= 1'b0;
            memCsN_r <= CS_NONE;  memWeN_r <= 1'b1;  memRefN_r <= 1'b1;
            memAddr_r <= '0;  memBa_r <= '0;
            memDqO_r <= '0;  memDqOe_r <= 1'b0;  memWm_r <= '0;
        end else begin
            stR <= stNxt;  idxR <= idxNxt;  cntR <= cntNxt;
            latR <= latNxt;  bcR <= bcNxt;  trcR <= trcNxt;
            arefR <= arefNxt;  isWrR <= isWrNxt;
            reqReady_r <= ready_nxt;  reqErr_r <= err_nxt;  initDone_r <= done_nxt;
            wrTake_r <= take_nxt;  rdData_r <= rdData_nxt;  rdValid_r <= rdv_nxt;
            memCsN_r <= cs_nxt;  memWeN_r <= we_nxt;  memRefN_r <= ref_nxt;
            memAddr_r <= addr_nxt;  memBa_r <= ba_nxt;
            memDqO_r <= dqO_nxt;  memDqOe_r <= oe_nxt;  memWm_r <= wm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks; helpers below are read only by them
    logic       pinCmd, pinMrs, pinRd;
    logic [5:0] sinceCmd;
    logic [4:0] runCnt;
    logic [1:0] mrsSeen;
    assign pinCmd = (memCsN_r != CS_NONE);
    assign pinMrs = pinCmd && !memWeN_r && !memRefN_r;
    assign pinRd  = pinCmd && memWeN_r && memRefN_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sinceCmd <= '0;  runCnt <= '0;  mrsSeen <= '0;
        end else begin
            sinceCmd <= pinCmd ? 6'd1 : (sinceCmd == 6'h3f ? sinceCmd : sinceCmd + 6'd1);
            runCnt <= memDqOe_r ? runCnt + 5'd1 : 5'd0;
            mrsSeen <= (pinMrs && mrsSeen != 2'd3) ? mrsSeen + 2'd1 : mrsSeen;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_dq_width: assert property (DQ_W == 18 || DQ_W == 36)
        else $error("data width per device not 18 or 36");
    a_wm_absent: assert property (!WM_EN |-> memWm_r == '0)
        else $error("write mask driven while disabled");
    a_bus_double: assert property (TOT_W == (WIDTH_EXP ? 2 : 1) * DQ_W && TOT_W <= MAX_W)
        else $error("combined bus width wrong");
    a_cs_paired: assert property (WIDTH_EXP && pinCmd |-> memCsN_r == CS_BOTH)
        else $error("devices not selected together");
    a_die_select: assert property (DEPTH_EXP && pinCmd && !pinMrs |-> $onehot(~memCsN_r))
        else $error("depth access selects wrong dies");
    a_pin_widths: assert property ($bits(memAddr_r) == ADDR_W && $bits(memBa_r) == BA_W)
        else $error("address pin widths differ from parameters");
    a_read_lat: assert property ($rose(rdValid_r) |-> sinceCmd == 6'(latR) + 6'd1)
        else $error("read capture not at latency");
    a_trc_word: assert property (pinMrs && memBa_r == '0 |->
        memAddr_r[MR0_LAT_LSB +: LAT_W] == cfgLat
        && memAddr_r[MR0_TRC_LSB +: TRC_W] == cfgTrc && trcR != '0)
        else $error("row cycle or latency word wrong");
    a_mr1_fields: assert property (pinMrs && memBa_r == BA_W'(1) |->
        memAddr_r[MR1_ARF_POS] == arefR && memAddr_r[MR1_DRV_POS] == cfgDrive
        && memAddr_r[MR1_ODT_LSB +: ODT_W] == cfgOdt)
        else $error("mode word one fields wrong");
    a_ref_form: assert property (pinCmd && !memRefN_r && memWeN_r && arefR |->
        memBa_r == '0 && popCnt(memAddr_r[NB-1:0]) <= (BA_W + 1)'(MAX_MB))
        else $error("multi-bank refresh form wrong");
    a_wp_word: assert property (pinMrs && memBa_r == BA_W'(2) |->
        memAddr_r[MR2_WP_LSB +: WP_W] == cfgWrProto)
        else $error("write protocol not programmed");
    a_burst_len: assert property ($fell(memDqOe_r) |-> runCnt == bcR)
        else $error("write burst length wrong");
    a_mrs_first: assert property (pinCmd && !pinMrs |-> mrsSeen == 2'd3 && initDone_r)
        else $error("command before all mode words");

    c_read: cover property (pinRd ##[1:30] $fell(rdValid_r));
    c_write: cover property ($fell(memDqOe_r));
    c_ref_err: cover property (reqErr_r);
    c_init: cover property ($rose(initDone_r));
endmodule : lld_cfg_ctrl

// File: testbench/lld_mem_model.sv
`timescale 1ns/1ps
module lld_mem_model #(
    parameter int W  = 72,
    parameter int AW = 20,
    parameter int BW = 4
) (
    input  wire logic          clk,      // memory clock
    input  wire logic          nrst,     // controller reset, seen on the board
    input  wire logic [1:0]    csN,      // chip selects, low active
    input  wire logic          weN,      // write enable, low active
    input  wire logic          refN,     // refresh strobe, low active
    input  wire logic [AW-1:0] addr,     // address pins
    input  wire logic [BW-1:0] ba,       // bank pins
    input  wire logic [W-1:0]  dqO,      // data from controller
    input  wire logic          dqOe,     // controller drives data
    output logic      [W-1:0]  dqI,      // data to controller
    output logic      [7:0]    mr [3],   // captured mode words
    output logic      [BW-1:0] refBa,    // last refresh bank
    output logic      [AW-1:0] refAddr,  // last refresh address
    output int                 badCount  // protocol slips seen
);
    logic [W-1:0] mem [int];
    int           nMr = 0, rdDly = 0, rdLeft = 0, rdKey = 0, wrDly = 0, wrLeft = 0, wrKey = 0;
    int           lat, bc;
    initial badCount = 0;
    initial dqI = '0;
    // timing decoded from the words received, not from the controller inputs
    assign lat = (mr[0][7:4] == 4'h0) ? 1 : int'(mr[0][7:4]);
    assign bc = (mr[1][5:4] == 2'h0) ? 2 : ((mr[1][5:4] == 2'h1) ? 4 : 8);
    ////////////////////////////////////////////////////////////////////////
    // command decode, then data beats; a released bus toggles so stale data never matches
    always @(posedge clk) begin
        if (!nrst)
            nMr = 0;
        else if (csN != 2'b11) begin
            if (csN != 2'b00)
                badCount++;
            if (!weN && !refN) begin
                mr[ba] <= addr[7:0];
                nMr++;
            end else begin
                if (nMr < 3)
                    badCount++;
                if (weN && refN) begin
                    rdDly = lat;
                    rdLeft = bc;
                    rdKey = int'({ba, addr}) * 8;
                end else if (!weN) begin
                    wrDly = lat + 1;
                    wrLeft = bc;
                    wrKey = int'({ba, addr}) * 8;
                end else begin
                    refBa <= ba;
                    refAddr <= addr;
                end
            end
        end
        if (rdLeft > 0 && rdDly <= 1) begin
            dqI <= mem.exists(rdKey) ? mem[rdKey] : ~dqI;
            rdKey++;
            rdLeft--;
        end else begin
            rdDly = (rdLeft > 0) ? rdDly - 1 : rdDly;
            dqI <= ~dqI;
        end
        if (wrLeft > 0 && wrDly <= 1) begin
            if (!dqOe)
                badCount++;
            mem[wrKey] = dqO;
            wrKey++;
            wrLeft--;
        end else if (wrLeft > 0)
            wrDly--;
    end
endmodule : lld_mem_model

// File: testbench/low_latency_dram_topology_mode_config_tb.sv
`timescale 1ns/1ps
module low_latency_dram_topology_mode_config_tb;
    import lld_pkg::*;
    localparam int TW = 72;
    logic          clk, nrst, cfgDrive, cfgArefMb, reqValid, reqReady_r, reqErr_r, initDone_r;
    logic          wrTake_r, rdValid_r, memWeN_r, memRefN_r, memDqOe_r;
    logic [3:0]    cfgTrc, cfgLat, reqBank, memBa_r, refBa, b [4];
    logic [1:0]    cfgOdt, cfgBurst, cfgWrProto, memCsN_r;
    lld_cmd_t      reqCmd;
    logic [19:0]   reqAddr, memAddr_r, refAddr, a [4];
    logic [TW-1:0] wrData, memDqI, rdData_r, memDqO_r, exp [int];
    logic [7:0]    wrMask, memWm_r, mr [3];
    logic [15:0]   seed = 16'h5558;
    int            n_errors = 0, compares = 0, cycles = 0, badCount, bc, r, i;

    // x36 devices with width expansion: 72-bit bus, eight mask pins
    lld_cfg_ctrl #(.DQ_W(36), .WIDTH_EXP(1'b1))
        i_lld_cfg_ctrl (.clk(clk), .nrst(nrst), .cfgTrc(cfgTrc), .cfgLat(cfgLat),
        .cfgDrive(cfgDrive), .cfgOdt(cfgOdt), .cfgArefMb(cfgArefMb), .cfgBurst(cfgBurst),
        .cfgWrProto(cfgWrProto), .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
        .reqBank(reqBank), .wrData(wrData), .wrMask(wrMask), .memDqI(memDqI),
        .reqReady_r(reqReady_r), .reqErr_r(reqErr_r), .initDone_r(initDone_r),
        .wrTake_r(wrTake_r), .rdData_r(rdData_r), .rdValid_r(rdValid_r), .memCsN_r(memCsN_r),
        .memWeN_r(memWeN_r), .memRefN_r(memRefN_r), .memAddr_r(memAddr_r), .memBa_r(memBa_r),
        .memDqO_r(memDqO_r), .memDqOe_r(memDqOe_r), .memWm_r(memWm_r));
    lld_mem_model #(.W(TW)) i_lld_mem_model (.clk(clk), .nrst(nrst),
        .csN(memCsN_r), .weN(memWeN_r), .refN(memRefN_r), .addr(memAddr_r), .ba(memBa_r),
        .dqO(memDqO_r), .dqOe(memDqOe_r), .dqI(memDqI), .mr(mr), .refBa(refBa),
        .refAddr(refAddr), .badCount(badCount));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // lfsr keeps the run repeatable
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    task automatic check(input logic [TW-1:0] seen, input logic [TW-1:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // entered at a falling edge; waits for ready high, then drives the request for the one cycle of the taking edge
    task automatic send(input lld_cmd_t c, input logic [19:0] ad, input logic [3:0] bk);
        int k;
        for (k = 0; k < 200 && reqReady_r !== 1'b1; k++)
            @(negedge clk);
        reqValid = 1'b1;
        reqCmd = c;
        reqAddr = ad;
        reqBank = bk;
        @(negedge clk);
        reqValid = 1'b0;
    endtask : send
    // one burst; write beats handed over while wrTake_r stands, read beats compared
    task automatic xfer(input lld_cmd_t c, input logic [19:0] ad, input logic [3:0] bk);
        logic [79:0] w;
        int          k, n, key;
        key = int'({bk, ad}) * 8;
        n = 0;
        send(c, ad, bk);
        for (k = 0; k < 40; k++) begin
            // mask pins show the mask handed over with the beat now on the data pins
            if (c == CMD_WRITE && memDqOe_r === 1'b1)
                check(TW'(memWm_r), TW'(wrMask));
            if (c == CMD_WRITE && wrTake_r === 1'b1) begin
                w = {rnd(), rnd(), rnd(), rnd(), rnd()};
                wrData = w[TW-1:0];
                wrMask = w[79:72];
                exp[key + n] = w[TW-1:0];
                n++;
            end
            if (c == CMD_READ && rdValid_r === 1'b1) begin
                check(rdData_r, exp[key + n]);
                n++;
            end
            @(negedge clk);
        end
        check(TW'(n), TW'(bc));
    endtask : xfer
    task automatic refr(input logic [19:0] ad, input logic [3:0] bk, input logic bad);
        logic err;
        err = 1'b0;
        send(CMD_REFR, ad, bk);
        repeat (3) begin
            err = err | (reqErr_r === 1'b1);
            @(negedge clk);
        end
        check(TW'(err), TW'(bad));
        if (!bad)
            check(TW'(refBa), cfgArefMb ? '0 : TW'(bk));
        if (!bad && cfgArefMb)
            check(TW'(refAddr[15:0]), TW'(ad[15:0]));
    endtask : refr
    ////////////////////////////////////////////////////////////////////////
    // cut a hang short; the whole run needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {nrst, reqValid, reqAddr, reqBank, wrData, wrMask} = '0;
        reqCmd = CMD_READ;
        for (r = 0; r < 2; r++) begin
            nrst = 1'b0;
            cfgTrc = (r == 0) ? 4'h0 : 4'(1 + rnd() % 15); // zero: row cycle follows latency
            cfgLat = 4'(1 + rnd() % 15);
            {cfgDrive, cfgOdt, cfgBurst, cfgWrProto} = 7'(rnd());
            cfgArefMb = r[0];
            bc = (cfgBurst == 2'h0) ? 2 : ((cfgBurst == 2'h1) ? 4 : 8);
            repeat (2) @(negedge clk);
            nrst = 1'b1;
            for (i = 0; i < 100 && reqReady_r !== 1'b1; i++)
                @(negedge clk);
            check(TW'(initDone_r), TW'(1));
            check(TW'(mr[0]), TW'({cfgLat, cfgTrc}));
            check(TW'(mr[1]), TW'({cfgBurst, cfgArefMb, cfgOdt, cfgDrive}));
            check(TW'(mr[2]), TW'(cfgWrProto));
            for (i = 0; i < 4; i++) begin
                a[i] = (i == 0) ? 20'hf_ffff : 20'({rnd(), rnd()});
                b[i] = (i == 0) ? 4'hf : 4'(rnd());
                xfer(CMD_WRITE, a[i], b[i]);
            end
            for (i = 3; i >= 0; i--)
                xfer(CMD_READ, a[i], b[i]);
            refr(20'h0_8421, 4'(rnd()), 1'b0);
            if (cfgArefMb)
                refr(20'h0_001f, 4'h3, 1'b1);
            check(TW'(badCount), '0);
            $display("configuration run %0d done", r);
        end
        end_of_test();
    end
endmodule : low_latency_dram_topology_mode_config_tb
